// *** rtl/psh_power_state_handshake.sv ***
// Power-state handshake, button status and backup-charger registers
`timescale 1ns/10ps
module psh_power_state_handshake
    import psh_pkg::*;
#(
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
    parameter int HOLD_STEP_LEN = HOLD_STEP_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       button_input_n,
    input  wire logic       shallow_sleep_n,
    input  wire logic       sleep_state3_n,
    input  wire logic       sleep_state4_n,
    input  wire logic       platform_reset_n,
    input  wire logic       standbyRailsGood,
    input  wire logic       softStartDone,
    input  wire logic       memConverterAbove90,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output logic [7:0]      regRdData,
    output logic            resume_reset_n,
    output logic            memory_power_good,
    output logic            always_on_power_good,
    output logic            core_power_good,
    output logic            standbyRailsEn,
    output logic            activeRailsEn,
    output logic            memConverterEn,
    output logic            powerSaveMode,
    output logic            deepSleep,
    output logic            coldOff,
    output logic            buttonOutN,
    output logic            hostOutOfReset,
    output logic [1:0]      backup_charge_voltage_sel,
    output logic [1:0]      backup_charge_resistance_sel
);

    // ****************************************************************
    // Button path
    // ****************************************************************
    logic       button_level;
    logic       levelPrev_reg;
    logic [3:0] button_hold_time;
    logic       pressStart;
    logic       clearHold;
    logic [3:0] fault_hold_limit_reg;
    logic       faultMatch;
    psh_state_t state_reg;
    psh_state_t state_next;

    psh_debounce #(
        .CYCLES   (DEBOUNCE_LEN)
    ) u_debounce (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .rawN     (button_input_n),
        .levelReg (button_level)
    );

    // Falling edge of debounced level marks a new press
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            levelPrev_reg <= 1'b1;
        end else begin
            levelPrev_reg <= button_level;
        end
    end
    assign pressStart = levelPrev_reg && !button_level;

    // Clear-hold and clear-fault strobes act on the same timer
    assign clearHold = regWrEn && regAddr == BUTTON_CONFIG_ADDR &&
        (regWrData[CLEAR_HOLD_BIT] || regWrData[CLEAR_FAULT_BIT]);

    psh_hold_timer #(
        .STEP       (HOLD_STEP_LEN)
    ) u_hold_timer (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .pressed    (!button_level),
        .pressStart (pressStart),
        .clearHold  (clearHold),
        .holdReg    (button_hold_time)
    );

    // Forced shutdown on a match while powered
    assign faultMatch = fault_hold_limit_reg != FAULT_DISABLED &&
        button_hold_time == fault_hold_limit_reg &&
        state_reg != PSH_FULLY_OFF;

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Fault limit; clear bits are strobes and are not stored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_hold_limit_reg <= BUTTON_CONFIG_RESET[3:0];
        end else if (regWrEn && regAddr == BUTTON_CONFIG_ADDR) begin
            fault_hold_limit_reg <= regWrData[3:0];
        end
    end

    // Backup charger settings, cleared on button wake from off
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            backup_charge_voltage_sel    <= CHARGE_VOLT_RESET;
            backup_charge_resistance_sel <= CHARGE_RES_RESET;
        end else if (state_reg == PSH_FULLY_OFF && pressStart) begin
            backup_charge_voltage_sel    <= CHARGE_VOLT_RESET;
            backup_charge_resistance_sel <= CHARGE_RES_RESET;
        end else if (regWrEn && regAddr == CHARGE_VOLT_ADDR) begin
            backup_charge_voltage_sel    <= regWrData[1:0];
        end else if (regWrEn && regAddr == CHARGE_RES_ADDR) begin
            backup_charge_resistance_sel <= regWrData[1:0];
        end
    end

    // Read port; status register has no writable bits
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                BUTTON_CONFIG_ADDR: regRdData <= {4'h0, fault_hold_limit_reg};
                BUTTON_STATUS_ADDR: regRdData <= {3'h0, button_level,
                    button_hold_time};
                CHARGE_VOLT_ADDR:   regRdData <= {6'h00,
                    backup_charge_voltage_sel};
                CHARGE_RES_ADDR:    regRdData <= {6'h00,
                    backup_charge_resistance_sel};
                default:            regRdData <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Power state machine
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        if (faultMatch) begin
            state_next = PSH_FULLY_OFF;
        end else begin
            case (state_reg)
                PSH_FULLY_OFF: begin
                    if (pressStart) state_next = PSH_STANDBY_UP;
                end
                PSH_STANDBY_UP: begin
                    if (standbyRailsGood) state_next = PSH_STANDBY;
                end
                PSH_STANDBY: begin
                    if (sleep_state3_n && sleep_state4_n) begin
                        state_next = PSH_ACTIVE_UP;
                    end
                end
                PSH_ACTIVE_UP: begin
                    if (!sleep_state3_n) begin
                        state_next = PSH_SLEEP3;
                    end else if (softStartDone) begin
                        state_next = PSH_ACTIVE;
                    end
                end
                PSH_ACTIVE: begin
                    if (!sleep_state3_n) begin
                        state_next = PSH_SLEEP3;
                    end else if (!shallow_sleep_n) begin
                        state_next = PSH_SHALLOW_IDLE;
                    end
                end
                PSH_SHALLOW_IDLE: begin
                    if (!sleep_state3_n) begin
                        state_next = PSH_SLEEP3;
                    end else if (shallow_sleep_n) begin
                        state_next = PSH_ACTIVE;
                    end
                end
                PSH_SLEEP3: begin
                    // Sleep-4 counts only while sleep-3 is still low
                    if (sleep_state3_n) begin
                        state_next = PSH_ACTIVE_UP;
                    end else if (!sleep_state4_n) begin
                        state_next = PSH_SLEEP4;
                    end
                end
                PSH_SLEEP4: begin
                    if (sleep_state3_n || sleep_state4_n) begin
                        state_next = PSH_SLEEP3;
                    end
                end
                default: state_next = PSH_FULLY_OFF;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= PSH_FULLY_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Rail enables, power-save and deep-sleep follow the next state; coldOff registers faultMatch
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            standbyRailsEn <= 1'b0;
            activeRailsEn  <= 1'b0;
            memConverterEn <= 1'b0;
            powerSaveMode  <= 1'b0;
            deepSleep      <= 1'b0;
            coldOff        <= 1'b0;
        end else begin
            standbyRailsEn <= state_next != PSH_FULLY_OFF;
            activeRailsEn  <= state_next == PSH_ACTIVE_UP ||
                state_next == PSH_ACTIVE || state_next == PSH_SHALLOW_IDLE;
            memConverterEn <= state_next == PSH_ACTIVE_UP ||
                state_next == PSH_ACTIVE || state_next == PSH_SHALLOW_IDLE;
            powerSaveMode  <= state_next == PSH_SHALLOW_IDLE;
            deepSleep      <= state_next == PSH_SLEEP4;
            coldOff        <= faultMatch;
        end
    end

    // ****************************************************************
    // Handshake outputs to the host
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            resume_reset_n       <= 1'b0;
            memory_power_good    <= 1'b0;
            always_on_power_good <= 1'b0;
            core_power_good      <= 1'b0;
            buttonOutN           <= 1'b1;
            hostOutOfReset       <= 1'b0;
        end else begin
            resume_reset_n       <= state_next != PSH_FULLY_OFF &&
                state_next != PSH_STANDBY_UP;
            memory_power_good    <= memConverterEn &&
                memConverterAbove90;
            always_on_power_good <= state_next == PSH_ACTIVE ||
                state_next == PSH_SHALLOW_IDLE;
            core_power_good      <= state_next == PSH_ACTIVE ||
                state_next == PSH_SHALLOW_IDLE;
            buttonOutN           <= button_level;
            hostOutOfReset       <= platform_reset_n;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_level_read;
        @(posedge sys_clk) disable iff (sys_rst)
        regRdEn && regAddr == BUTTON_STATUS_ADDR |=>
            regRdData[LEVEL_BIT] == $past(button_level) &&
            regRdData[7:5] == 3'h0;
    endproperty
    a_level_read: assert property (p_level_read)
        else $error("Status level bit does not match debounced level");

    property p_hold_read;
        @(posedge sys_clk) disable iff (sys_rst)
        regRdEn && regAddr == BUTTON_STATUS_ADDR |=>
            regRdData[3:0] == $past(button_hold_time);
    endproperty
    a_hold_read: assert property (p_hold_read)
        else $error("Status hold field does not match hold timer");

    property p_charger_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        state_reg == PSH_FULLY_OFF && pressStart |=>
            backup_charge_voltage_sel == CHARGE_VOLT_RESET &&
            backup_charge_resistance_sel == CHARGE_RES_RESET;
    endproperty
    a_charger_clear: assert property (p_charger_clear)
        else $error("Charger settings not cleared on wake");

    property p_resume_release;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(resume_reset_n) |-> $past(standbyRailsGood) &&
            $past(state_reg) == PSH_STANDBY_UP;
    endproperty
    a_resume_release: assert property (p_resume_release)
        else $error("Resume reset released before standby rails good");

    property p_resume_off;
        @(posedge sys_clk) disable iff (sys_rst)
        state_reg == PSH_FULLY_OFF |-> !resume_reset_n;
    endproperty
    a_resume_off: assert property (p_resume_off)
        else $error("Resume reset high in fully-off state");

    property p_memory_good;
        @(posedge sys_clk) disable iff (sys_rst)
        !memConverterEn |=> !memory_power_good;
    endproperty
    a_memory_good: assert property (p_memory_good)
        else $error("Memory power good high with converter off");

    property p_always_on_good;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(always_on_power_good) |-> $past(softStartDone) &&
            core_power_good;
    endproperty
    a_always_on_good: assert property (p_always_on_good)
        else $error("Always-on good before soft start complete");

    property p_core_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        state_reg == PSH_SHALLOW_IDLE |-> core_power_good && powerSaveMode;
    endproperty
    a_core_idle: assert property (p_core_idle)
        else $error("Core good or power save low in shallow idle");

    property p_shallow_entry;
        @(posedge sys_clk) disable iff (sys_rst)
        state_reg == PSH_ACTIVE && !shallow_sleep_n && sleep_state3_n &&
            !faultMatch |=> powerSaveMode;
    endproperty
    a_shallow_entry: assert property (p_shallow_entry)
        else $error("Shallow sleep request did not enter power save");

    property p_deep_entry;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(state_reg == PSH_SLEEP4) |-> $past(state_reg) == PSH_SLEEP3 &&
            !$past(sleep_state3_n) && resume_reset_n;
    endproperty
    a_deep_entry: assert property (p_deep_entry)
        else $error("Deep sleep entered without sleep-3 asserted");

    property p_host_reset;
        @(posedge sys_clk) disable iff (sys_rst)
        ##1 hostOutOfReset == $past(platform_reset_n);
    endproperty
    a_host_reset: assert property (p_host_reset)
        else $error("Host reset status does not follow its input");

    property p_fault_off;
        @(posedge sys_clk) disable iff (sys_rst)
        faultMatch |=> state_reg == PSH_FULLY_OFF && coldOff ##1
            !resume_reset_n;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("Fault limit match did not force cold off");

    property p_config_read;
        @(posedge sys_clk) disable iff (sys_rst)
        regRdEn && regAddr == BUTTON_CONFIG_ADDR |=> regRdData[7:4] == 4'h0;
    endproperty
    a_config_read: assert property (p_config_read)
        else $error("Clear bits did not read back zero");

endmodule

// *** common/psh_pkg.sv ***
// Constants and types shared by the power-state handshake block
package psh_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ          = 20_000_000;
    localparam int DEBOUNCE_MS     = 30;
    localparam int HOLD_STEP_MS    = 500;
    localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int HOLD_STEP_CYCLES = CLK_HZ / 1000 * HOLD_STEP_MS;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] BUTTON_CONFIG_ADDR  = 8'h26;
    localparam logic [7:0] BUTTON_STATUS_ADDR  = 8'h27;
    localparam logic [7:0] CHARGE_VOLT_ADDR    = 8'h28;
    localparam logic [7:0] CHARGE_RES_ADDR     = 8'h29;

    // ****************************************************************
    // Reset values and field positions
    // ****************************************************************
    localparam logic [7:0] BUTTON_CONFIG_RESET = 8'h08;
    localparam logic [7:0] BUTTON_STATUS_RESET = 8'h10;
    localparam logic [1:0] CHARGE_VOLT_RESET   = 2'h0;
    localparam logic [1:0] CHARGE_RES_RESET    = 2'h0;
    localparam int         LEVEL_BIT           = 4;
    localparam int         HOLD_LSB            = 0;
    localparam int         CLEAR_HOLD_BIT      = 5;
    localparam int         CLEAR_FAULT_BIT     = 4;
    localparam logic [3:0] HOLD_MAX            = 4'hF;
    localparam logic [3:0] FAULT_DISABLED      = 4'h0;

    // ****************************************************************
    // Power states
    // ****************************************************************
    typedef enum logic [2:0] {
        PSH_FULLY_OFF,
        PSH_STANDBY_UP,
        PSH_STANDBY,
        PSH_ACTIVE_UP,
        PSH_ACTIVE,
        PSH_SHALLOW_IDLE,
        PSH_SLEEP3,
        PSH_SLEEP4
    } psh_state_t;

endpackage

// *** rtl/psh_debounce.sv ***
// Button debounce filter
`timescale 1ns/10ps
module psh_debounce
    import psh_pkg::*;
#(
    parameter int CYCLES = DEBOUNCE_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic rawN,
    output logic      levelReg
);

    logic [23:0] countReg;

    // ****************************************************************
    // Filter: level flips after the raw input differs for CYCLES
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            countReg <= 24'h000000;
            levelReg <= 1'b1;
        end else if (rawN == levelReg) begin
            countReg <= 24'h000000;
        end else if (countReg == 24'(CYCLES - 1)) begin
            countReg <= 24'h000000;
            levelReg <= rawN;
        end else begin
            countReg <= countReg + 24'h000001;
        end
    end

    property p_debounce_stable;
        @(posedge sys_clk) disable iff (sys_rst)
        $changed(levelReg) |-> $past(rawN) == levelReg &&
            $past(countReg) == 24'(CYCLES - 1);
    endproperty
    a_debounce_stable: assert property (p_debounce_stable)
        else $error("Debounced level changed before the filter time");

endmodule

// *** rtl/psh_hold_timer.sv ***
// Button hold-time measurement in half-second steps
`timescale 1ns/10ps
module psh_hold_timer
    import psh_pkg::*;
#(
    parameter int STEP = HOLD_STEP_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       pressed,
    input  wire logic       pressStart,
    input  wire logic       clearHold,
    output logic [3:0]      holdReg
);

    logic [23:0] stepReg;

    // ****************************************************************
    // Count half seconds of press, keep value after release
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stepReg <= 24'h000000;
            holdReg <= 4'h0;
        end else if (clearHold || pressStart) begin
            stepReg <= 24'h000000;
            holdReg <= 4'h0;
        end else if (pressed && holdReg != HOLD_MAX) begin
            if (stepReg == 24'(STEP - 1)) begin
                stepReg <= 24'h000000;
                holdReg <= holdReg + 4'h1;
            end else begin
                stepReg <= stepReg + 24'h000001;
            end
        end
    end

    property p_hold_monotonic;
        @(posedge sys_clk) disable iff (sys_rst)
        !$past(clearHold) && !$past(pressStart) |-> holdReg >= $past(holdReg);
    endproperty
    a_hold_monotonic: assert property (p_hold_monotonic)
        else $error("Hold time decreased without clear or new press");

    property p_hold_kept;
        @(posedge sys_clk) disable iff (sys_rst)
        !pressed && !clearHold && !pressStart |=> $stable(holdReg);
    endproperty
    a_hold_kept: assert property (p_hold_kept)
        else $error("Hold time changed while button released");

endmodule

// *** rtl/psh_unused_guard.sv ***
// Spare design file; the block needs no guard logic

// *** tb/psh_host_model.sv ***
// Behavioural host controller driving sleep and platform reset lines
`timescale 1ns/10ps
module psh_host_model (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic resume_reset_n,
    input  wire logic wantIdle,
    input  wire logic wantS3,
    input  wire logic wantS4,
    output logic      shallow_sleep_n,
    output logic      sleep_state3_n,
    output logic      sleep_state4_n,
    output logic      platform_reset_n
);
    // ****************************************************************
    // Host sequencing
    // ****************************************************************
    // Requests only once the host itself is out of reset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shallow_sleep_n  <= 1'h1;
            sleep_state3_n   <= 1'h1;
            sleep_state4_n   <= 1'h1;
            platform_reset_n <= 1'h0;
        end else begin
            platform_reset_n <= resume_reset_n;
            shallow_sleep_n  <= !(wantIdle && platform_reset_n);
            sleep_state3_n   <= !(wantS3 && platform_reset_n);
            sleep_state4_n   <= !(wantS4 && wantS3 &&
                platform_reset_n);
        end
    end
endmodule

// *** tb/psh_power_state_handshake_test.sv ***
// Self-checking bench for the power-state handshake block
`timescale 1ns/10ps
module psh_power_state_handshake_test;
    import psh_pkg::*;
    logic       sys_clk, sys_rst, button_input_n, shallow_sleep_n;
    logic       sleep_state3_n, sleep_state4_n, platform_reset_n;
    logic       standbyRailsGood, softStartDone, memConverterAbove90;
    logic       regWrEn, regRdEn, resume_reset_n, memory_power_good;
    logic       always_on_power_good, core_power_good, powerSaveMode;
    logic       deepSleep, coldOff, buttonOutN, hostOutOfReset;
    logic       wantIdle, wantS3, wantS4, sawCold, stbyEn, actEn, memEn;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [1:0] voltSel, resSel;
    int         n_mismatch, total_checks, i;

    // ****************************************************************
    // Design, host and clock
    // ****************************************************************
    psh_power_state_handshake #(.DEBOUNCE_LEN(4), .HOLD_STEP_LEN(8)) i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .button_input_n(button_input_n), .shallow_sleep_n(shallow_sleep_n),
        .sleep_state3_n(sleep_state3_n), .sleep_state4_n(sleep_state4_n),
        .platform_reset_n(platform_reset_n),
        .standbyRailsGood(standbyRailsGood), .softStartDone(softStartDone),
        .memConverterAbove90(memConverterAbove90), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .resume_reset_n(resume_reset_n),
        .memory_power_good(memory_power_good),
        .always_on_power_good(always_on_power_good),
        .core_power_good(core_power_good), .standbyRailsEn(stbyEn),
        .activeRailsEn(actEn), .memConverterEn(memEn),
        .powerSaveMode(powerSaveMode),
        .deepSleep(deepSleep), .coldOff(coldOff), .buttonOutN(buttonOutN),
        .hostOutOfReset(hostOutOfReset),
        .backup_charge_voltage_sel(voltSel),
        .backup_charge_resistance_sel(resSel));
    psh_host_model i_host (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .resume_reset_n(resume_reset_n),
        .wantIdle(wantIdle), .wantS3(wantS3), .wantS4(wantS4),
        .shallow_sleep_n(shallow_sleep_n), .sleep_state3_n(sleep_state3_n),
        .sleep_state4_n(sleep_state4_n), .platform_reset_n(platform_reset_n));
    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = !sys_clk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'h1;
        @(posedge sys_clk);
        regWrEn <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, exp, input string what);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'h1;
        @(posedge sys_clk);
        regRdEn <= 1'h0;
        #1;
        check(what, regRdData, exp);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {n_mismatch, total_checks} = '0;
        {sys_rst, button_input_n} = 2'h3;
        {standbyRailsGood, softStartDone, memConverterAbove90} = 3'h0;
        {regAddr, regWrData, regWrEn, regRdEn} = '0;
        {wantIdle, wantS3, wantS4, sawCold} = 4'h0;
        cyc(2);
        @(posedge sys_clk) sys_rst <= 1'h0;
        rd(BUTTON_STATUS_ADDR, 8'h10, "status");
        wr(CHARGE_VOLT_ADDR, 8'h03);
        wr(CHARGE_RES_ADDR, 8'h02);
        rd(CHARGE_VOLT_ADDR, 8'h03, "volt");
        wr(BUTTON_STATUS_ADDR, 8'h0F);
        rd(BUTTON_STATUS_ADDR, 8'h10, "status");
        wr(BUTTON_CONFIG_ADDR, 8'h20);
        rd(BUTTON_CONFIG_ADDR, 8'h00, "config");
        @(posedge sys_clk) button_input_n <= 1'h0;
        cyc(2);
        @(posedge sys_clk) button_input_n <= 1'h1;
        cyc(6);
        rd(BUTTON_STATUS_ADDR, 8'h10, "status");
        check("resume", resume_reset_n, 1'h0);
        @(posedge sys_clk) button_input_n <= 1'h0;
        cyc(200);
        rd(BUTTON_STATUS_ADDR, 8'h0F, "status");
        check("btnout", buttonOutN, 1'h0);
        check("stbyen", stbyEn, 1'h1);
        check("acten", actEn, 1'h0);
        rd(CHARGE_VOLT_ADDR, 8'h00, "volt");
        rd(CHARGE_RES_ADDR, 8'h00, "res");
        check("resume", resume_reset_n, 1'h0);
        @(posedge sys_clk) standbyRailsGood <= 1'h1;
        cyc(2);
        check("resume", resume_reset_n, 1'h1);
        @(posedge sys_clk) button_input_n <= 1'h1;
        cyc(8);
        rd(BUTTON_STATUS_ADDR, 8'h1F, "status");
        wr(BUTTON_CONFIG_ADDR, 8'h20);
        rd(BUTTON_STATUS_ADDR, 8'h10, "status");
        check("hostrun", hostOutOfReset, 1'h1);
        check("aongood", always_on_power_good, 1'h0);
        @(posedge sys_clk) {softStartDone, memConverterAbove90} <= 2'h3;
        cyc(3);
        check("aongood", always_on_power_good, 1'h1);
        check("coregood", core_power_good, 1'h1);
        check("memgood", memory_power_good, 1'h1);
        check("memen", memEn, 1'h1);
        @(posedge sys_clk) wantIdle <= 1'h1;
        cyc(3);
        check("psave", powerSaveMode, 1'h1);
        check("coregood", core_power_good, 1'h1);
        @(posedge sys_clk) {wantIdle, wantS3} <= 2'h1;
        cyc(4);
        check("memgood", memory_power_good, 1'h0);
        check("aongood", always_on_power_good, 1'h0);
        check("memen", memEn, 1'h0);
        check("acten", actEn, 1'h0);
        check("deep", deepSleep, 1'h0);
        @(posedge sys_clk) wantS4 <= 1'h1;
        cyc(3);
        check("deep", deepSleep, 1'h1);
        wr(BUTTON_CONFIG_ADDR, 8'h22);
        @(posedge sys_clk) button_input_n <= 1'h0;
        for (i = 0; i < 100 && resume_reset_n !== 1'h0; i++) begin
            cyc(1);
            sawCold |= coldOff;
        end
        check("resume", resume_reset_n, 1'h0);
        check("coldoff", sawCold, 1'h1);
        check("stbyen", stbyEn, 1'h0);
        cyc(3);
        check("hostrun", hostOutOfReset, 1'h0);
        test_done();
    end
endmodule
